/* File: include/dpf_pkg.sv */
// constants shared by the mode/flag fifo device end and its controller end
// assumes one clock for both ends and a power-of-two storage depth
package dpf_pkg;
  localparam int DPF_WIDE = 18;
  localparam int DPF_BYTE = 9;
  localparam int DPF_DEPTH = 2048;
  localparam int DPF_OFS_W = 16;
  localparam int DPF_PAR_BIT = 8;
  localparam int DPF_IGN_LO = 16;
  localparam int DPF_SEL_W = 3;
  // default offsets, indexed by {load, select1, select0}
  localparam logic [15:0] DPF_DEF_OFS [8] = '{16'h0007, 16'h000F, 16'h001F, 16'h003F,
                                              16'h007F, 16'h00FF, 16'h01FF, 16'h03FF};
  // controller register map, byte addresses
  localparam logic [7:0] DPF_A_CTRL = 8'h00;
  localparam logic [7:0] DPF_A_WDATA = 8'h04;
  localparam logic [7:0] DPF_A_RCMD = 8'h08;
  localparam logic [7:0] DPF_A_RDATA = 8'h0C;
  localparam logic [7:0] DPF_A_STATUS = 8'h10;
  localparam logic [7:0] DPF_A_SERIAL = 8'h14;
  // control register fields
  localparam int DPF_CB_MRS = 0;
  localparam int DPF_CB_RSYNC = 1;
  localparam int DPF_CB_WSYNC = 2;
  localparam int DPF_CB_ORDER = 3;
  localparam int DPF_CB_PAR = 4;
  localparam int DPF_CB_SEL0 = 5;
  localparam int DPF_CB_SEL1 = 6;
  localparam int DPF_CB_LD = 7;
  localparam int DPF_CB_FALLTHROUGH_MODE_SELECT = 8;
  localparam int DPF_CB_IN9 = 9;
  localparam int DPF_CB_OUT9 = 10;
  localparam int DPF_CTRL_W = 11;
  localparam logic [10:0] DPF_CTRL_RST = 11'h087;
  localparam int DPF_STAT_W = 7;
  localparam int DPF_HTRANS_ACT = 1;
  localparam int DPF_ADDR_W = 8;
endpackage

/* File: include/dpf_link_if.sv */
// pins between the fifo device end and the writer/reader controller end
// assumes both ends run on the same clock; no clocking block
`timescale 1ns/1ps
`default_nettype none
interface dpf_link_if;
  logic master_reset_n;
  logic read_port_timing_strap;
  logic write_port_timing_strap;
  logic byte_order_strap;
  logic parity_placement_strap;
  logic offset_select_bit0;
  logic offset_select_bit1;
  logic offset_load_enable;
  logic fallthrough_mode_select_si;
  logic in_width_x9;
  logic out_width_x9;
  logic [dpf_pkg::DPF_WIDE-1:0] write_data_in;
  logic write_en;
  logic read_en;
  logic serial_en;
  logic read_clock;
  logic [dpf_pkg::DPF_WIDE-1:0] read_data_out;
  logic empty_flag_n;
  logic full_flag_n;
  logic half_full_flag_n;
  logic almost_empty_flag;
  logic almost_full_flag;
  logic read_clock_echo;
  logic read_enable_echo;
  modport dev (
    input master_reset_n, read_port_timing_strap, write_port_timing_strap,
    input byte_order_strap, parity_placement_strap, offset_select_bit0,
    input offset_select_bit1, offset_load_enable, fallthrough_mode_select_si, in_width_x9,
    input out_width_x9, write_data_in, write_en, read_en, serial_en, read_clock,
    output read_data_out, empty_flag_n, full_flag_n, half_full_flag_n,
    output almost_empty_flag, almost_full_flag, read_clock_echo, read_enable_echo
  );
  modport host (
    output master_reset_n, read_port_timing_strap, write_port_timing_strap,
    output byte_order_strap, parity_placement_strap, offset_select_bit0,
    output offset_select_bit1, offset_load_enable, fallthrough_mode_select_si, in_width_x9,
    output out_width_x9, write_data_in, write_en, read_en, serial_en, read_clock,
    input read_data_out, empty_flag_n, full_flag_n, half_full_flag_n,
    input almost_empty_flag, almost_full_flag, read_clock_echo, read_enable_echo
  );
endinterface
`default_nettype wire

/* File: src/dpf_device.sv */
// fifo device end: mode straps caught in master reset, storage, flags, echoes
// assumes the controller shares CLOCK, so link inputs need no synchroniser
//
// Summary of operation
// - read strap high clocked, low asynchronous reads
// - asynchronous read port requires standard timing
// - write strap high clocked, low asynchronous writes
// - byte order strap low big, high little
// - write port takes 18 or 9 bits
// - standard mode: shared flag shows storage empty
// - fall-through mode: shared flag shows word presented
// - standard mode: shared flag shows storage full
// - fall-through mode: shared flag shows space available
// - read clock echoed only for clocked reads
// - read enable echoed only for clocked reads
// - select straps and load pick default offsets
// - shared pin picks fall-through in master reset
// - after reset shared pin is serial offset input
// - half-full output compares count with half capacity
// - parity strap low plain, high interspersed
// - almost-empty low below empty offset
// - almost-full low when free at most offset
// - split words: big first high, little first low
// - parallel offsets skip parity bit or top bits
`timescale 1ns/1ps
`default_nettype none
module dpf_device #(
  parameter int DEPTH = dpf_pkg::DPF_DEPTH,
  parameter int OFS_W = dpf_pkg::DPF_OFS_W
) (
  input wire logic CLOCK,
  input wire logic SRST,
  dpf_link_if.dev LINK
);
  import dpf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);

  logic rd_sync_q, wr_sync_q, little_q, ipar_q, fallthrough_mode_select_q, in9_q, out9_q;
  logic [OFS_W-1:0] empty_ofs_q, full_ofs_q;
  logic par_sel_q;
  logic wr_prev_q, rd_prev_q;
  logic [DPF_WIDE-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q, rptr_q;
  logic [CW-1:0] count_q;
  logic half_q;
  logic [DPF_WIDE-1:0] data_q;
  logic out_valid_q;
  logic clk_echo_q, ren_echo_q;

  // sync port takes a word each cycle the enable is high; async port once per pulse
  function automatic logic strobe(input logic lvl, input logic prev, input logic sync);
    strobe = sync ? lvl : (lvl & ~prev);
  endfunction

  function automatic logic [OFS_W-1:0] par_offset(input logic [DPF_WIDE-1:0] d,
                                                  input logic in9, input logic ipar);
    logic [DPF_WIDE-1:0] v;
    v = '0;
    if (in9) begin
      v = {10'h000, d[DPF_PAR_BIT-1:0]};
    end else if (ipar) begin
      v = {1'b0, d[DPF_WIDE-1:DPF_PAR_BIT+1], d[DPF_PAR_BIT-1:0]};
    end else begin
      v = {2'h0, d[DPF_IGN_LO-1:0]};
    end
    par_offset = v[OFS_W-1:0];
  endfunction

  function automatic logic [DPF_WIDE-1:0] pick(input logic [DPF_WIDE-1:0] w,
                                               input logic split, input logic half,
                                               input logic little);
    logic [DPF_BYTE-1:0] first, second;
    first = little ? w[DPF_BYTE-1:0] : w[DPF_WIDE-1:DPF_BYTE];
    second = little ? w[DPF_WIDE-1:DPF_BYTE] : w[DPF_BYTE-1:0];
    if (!split) begin
      pick = w;
    end else begin
      pick = {9'h000, half ? second : first};
    end
  endfunction

  logic in_mrs;
  logic wr_take, rd_take, mem_empty, split, push, adv, pop, consume;
  logic ser_load, par_load;
  logic [DPF_WIDE-1:0] store_word, present;
  logic [DPF_SEL_W-1:0] def_idx;

  assign in_mrs = ~LINK.master_reset_n;
  assign wr_take = strobe(LINK.write_en, wr_prev_q, wr_sync_q);
  assign rd_take = strobe(LINK.read_en, rd_prev_q, rd_sync_q);
  assign mem_empty = (count_q == '0);
  assign split = out9_q & ~in9_q;
  // offset load low steers a write into the offset registers instead of storage
  assign push = ~in_mrs & wr_take & LINK.offset_load_enable & (count_q != FULL_CNT);
  assign par_load = ~in_mrs & wr_take & ~LINK.offset_load_enable;
  assign ser_load = ~in_mrs & LINK.serial_en & ~LINK.offset_load_enable;
  assign consume = ~in_mrs & rd_take & LINK.offset_load_enable;
  assign adv = ~mem_empty & (fallthrough_mode_select_q ? (~out_valid_q | consume) : consume);
  assign pop = adv & ~(split & ~half_q);
  assign store_word = in9_q ? {9'h000, LINK.write_data_in[DPF_BYTE-1:0]}
                            : LINK.write_data_in;
  assign present = pick(mem_q[rptr_q], split, half_q, little_q);
  assign def_idx = {LINK.offset_load_enable, LINK.offset_select_bit1, LINK.offset_select_bit0};

  // straps are looked at only while master reset is low
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rd_sync_q <= 1'b1;
      wr_sync_q <= 1'b1;
      little_q <= 1'b0;
      ipar_q <= 1'b0;
      fallthrough_mode_select_q <= 1'b0;
      in9_q <= 1'b0;
      out9_q <= 1'b0;
    end else if (in_mrs) begin
      rd_sync_q <= LINK.read_port_timing_strap;
      wr_sync_q <= LINK.write_port_timing_strap;
      little_q <= LINK.byte_order_strap;
      ipar_q <= LINK.parity_placement_strap;
      // fall-through is refused with an async read port
      fallthrough_mode_select_q <= LINK.fallthrough_mode_select_si & LINK.read_port_timing_strap;
      in9_q <= LINK.in_width_x9;
      out9_q <= LINK.out_width_x9;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      empty_ofs_q <= OFS_W'(DPF_DEF_OFS[0]);
      full_ofs_q <= OFS_W'(DPF_DEF_OFS[0]);
      par_sel_q <= 1'b0;
    end else if (in_mrs) begin
      empty_ofs_q <= OFS_W'(DPF_DEF_OFS[def_idx]);
      full_ofs_q <= OFS_W'(DPF_DEF_OFS[def_idx]);
      par_sel_q <= 1'b0;
    end else if (ser_load) begin
      // serial stream fills empty offset first, msb first, then full offset
      {empty_ofs_q, full_ofs_q} <= {empty_ofs_q[OFS_W-2:0], full_ofs_q, LINK.fallthrough_mode_select_si};
    end else if (par_load) begin
      if (!par_sel_q) begin
        empty_ofs_q <= par_offset(LINK.write_data_in, in9_q, ipar_q);
      end else begin
        full_ofs_q <= par_offset(LINK.write_data_in, in9_q, ipar_q);
      end
      par_sel_q <= ~par_sel_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= LINK.write_en;
      rd_prev_q <= LINK.read_en;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (push) begin
      mem_q[wptr_q] <= store_word;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST || in_mrs) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      half_q <= 1'b0;
    end else begin
      if (push) begin
        wptr_q <= AW'(wptr_q + 1'b1);
      end
      if (adv) begin
        half_q <= split & ~half_q;
      end
      if (pop) begin
        rptr_q <= AW'(rptr_q + 1'b1);
      end
      if (push && !pop) begin
        count_q <= CW'(count_q + 1'b1);
      end else if (pop && !push) begin
        count_q <= CW'(count_q - 1'b1);
      end
    end
  end

  // in fall-through the output register preloads the head word without a read
  always_ff @(posedge CLOCK) begin
    if (SRST || in_mrs) begin
      data_q <= '0;
      out_valid_q <= 1'b0;
    end else if (adv) begin
      data_q <= present;
      out_valid_q <= 1'b1;
    end else if (consume) begin
      out_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      clk_echo_q <= 1'b0;
      ren_echo_q <= 1'b0;
    end else begin
      clk_echo_q <= rd_sync_q & LINK.read_clock;
      ren_echo_q <= rd_sync_q & LINK.read_en;
    end
  end

  assign LINK.read_data_out = data_q;
  assign LINK.empty_flag_n = fallthrough_mode_select_q ? ~out_valid_q : ~mem_empty;
  assign LINK.full_flag_n = fallthrough_mode_select_q ? (count_q == FULL_CNT) : (count_q != FULL_CNT);
  assign LINK.half_full_flag_n = ~(count_q > HALF_CNT);
  assign LINK.almost_empty_flag = (int'(count_q) >= int'(empty_ofs_q));
  assign LINK.almost_full_flag = ((DEPTH - int'(count_q)) > int'(full_ofs_q));
  assign LINK.read_clock_echo = clk_echo_q;
  assign LINK.read_enable_echo = ren_echo_q;
endmodule
`default_nettype wire

/* File: src/dpf_host.sv */
// writer/reader controller end: AHB-Lite registers drive straps and strobes
// assumes a zero-wait single-slave AHB-Lite bus on the same clock as the link
`timescale 1ns/1ps
`default_nettype none
module dpf_host (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  dpf_link_if.host LINK
);
  import dpf_pkg::*;

  logic [DPF_CTRL_W-1:0] ctrl_q;
  logic [DPF_WIDE-1:0] wdata_q, rdata_q;
  logic wr_pulse_q, rd_pulse_q, ser_pulse_q, ser_bit_q, rclk_q;
  logic dphase_wr_q;
  logic [DPF_ADDR_W-1:0] addr_q;
  logic [31:0] hrdata_q;
  logic take, rsync;
  logic [DPF_STAT_W-1:0] status;

  assign take = HSEL & HTRANS[DPF_HTRANS_ACT] & HREADY;
  assign rsync = ctrl_q[DPF_CB_RSYNC];
  assign status = {LINK.read_enable_echo, LINK.read_clock_echo, LINK.almost_full_flag,
                   LINK.almost_empty_flag, LINK.half_full_flag_n, LINK.full_flag_n,
                   LINK.empty_flag_n};

  function automatic logic [31:0] read_word(input logic [DPF_ADDR_W-1:0] a);
    if (a == DPF_A_CTRL) begin
      read_word = {21'h00_0000, ctrl_q};
    end else if (a == DPF_A_RDATA) begin
      read_word = {14'h0000, rdata_q};
    end else if (a == DPF_A_STATUS) begin
      read_word = {25'h000_0000, status};
    end else begin
      read_word = 32'h0000_0000;
    end
  endfunction

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      dphase_wr_q <= 1'b0;
      addr_q <= '0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      dphase_wr_q <= take & HWRITE;
      if (take) begin
        addr_q <= HADDR[DPF_ADDR_W-1:0];
        hrdata_q <= HWRITE ? 32'h0000_0000 : read_word(HADDR[DPF_ADDR_W-1:0]);
      end
    end
  end

  // strobes last one cycle; back-to-back bus writes give strobes in consecutive cycles with no low cycle between them
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctrl_q <= DPF_CTRL_RST;
      wdata_q <= '0;
      ser_bit_q <= 1'b0;
      wr_pulse_q <= 1'b0;
      rd_pulse_q <= 1'b0;
      ser_pulse_q <= 1'b0;
    end else begin
      wr_pulse_q <= dphase_wr_q && (addr_q == DPF_A_WDATA);
      rd_pulse_q <= dphase_wr_q && (addr_q == DPF_A_RCMD);
      ser_pulse_q <= dphase_wr_q && (addr_q == DPF_A_SERIAL);
      if (dphase_wr_q && addr_q == DPF_A_CTRL) begin
        ctrl_q <= HWDATA[DPF_CTRL_W-1:0];
      end else if (dphase_wr_q && addr_q == DPF_A_WDATA) begin
        wdata_q <= HWDATA[DPF_WIDE-1:0];
      end else if (dphase_wr_q && addr_q == DPF_A_SERIAL) begin
        ser_bit_q <= HWDATA[0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rdata_q <= '0;
      rclk_q <= 1'b0;
    end else begin
      rdata_q <= LINK.read_data_out;
      rclk_q <= ~rclk_q;
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  assign LINK.master_reset_n = ~ctrl_q[DPF_CB_MRS];
  assign LINK.read_port_timing_strap = rsync;
  assign LINK.write_port_timing_strap = ctrl_q[DPF_CB_WSYNC];
  assign LINK.byte_order_strap = ctrl_q[DPF_CB_ORDER];
  assign LINK.parity_placement_strap = ctrl_q[DPF_CB_PAR];
  assign LINK.offset_select_bit0 = ctrl_q[DPF_CB_SEL0];
  assign LINK.offset_select_bit1 = ctrl_q[DPF_CB_SEL1];
  assign LINK.offset_load_enable = ctrl_q[DPF_CB_LD];
  assign LINK.in_width_x9 = ctrl_q[DPF_CB_IN9];
  assign LINK.out_width_x9 = ctrl_q[DPF_CB_OUT9];
  // in reset the shared pin carries the mode, afterwards the serial bit
  assign LINK.fallthrough_mode_select_si = ctrl_q[DPF_CB_MRS] ? (ctrl_q[DPF_CB_FALLTHROUGH_MODE_SELECT] & rsync)
                                           : ser_bit_q;
  assign LINK.write_data_in = ctrl_q[DPF_CB_IN9] ? {9'h000, wdata_q[DPF_BYTE-1:0]}
                                                 : wdata_q;
  assign LINK.write_en = wr_pulse_q;
  assign LINK.read_en = rd_pulse_q;
  assign LINK.serial_en = ser_pulse_q;
  assign LINK.read_clock = rclk_q;
endmodule
`default_nettype wire

/* File: tb/dpf_link_props.sv */
// concurrent checks on the link between the fifo device end and its controller end
// assumes one clock for both ends; master reset comes from the controller
`timescale 1ns/1ps
`default_nettype none
module dpf_link_props (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic master_reset_n,
  input wire logic read_port_timing_strap,
  input wire logic fallthrough_mode_select_si,
  input wire logic read_clock,
  input wire logic read_en,
  input wire logic write_en,
  input wire logic read_clock_echo,
  input wire logic read_enable_echo,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic half_full_flag_n,
  input wire logic almost_empty_flag,
  input wire logic almost_full_flag
);
  logic rs_q;
  logic ft_q;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // mirror of the straps; fall-through is dropped with an unclocked read port
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rs_q <= 1'b1;
      ft_q <= 1'b0;
    end else if (!master_reset_n) begin
      rs_q <= read_port_timing_strap;
      ft_q <= fallthrough_mode_select_si & read_port_timing_strap;
    end
  end
  chk_rclk_copy:
    assert property (!$past(SRST) && rs_q && $past(rs_q) |-> read_clock_echo == $past(read_clock))
    else $error("read clock echo not a copy");
  chk_rclk_off:
    assert property (!rs_q && !$past(rs_q) |-> !read_clock_echo)
    else $error("read clock echo with unclocked reads");
  chk_ren_copy:
    assert property (!$past(SRST) && rs_q && $past(rs_q) |-> read_enable_echo == $past(read_en))
    else $error("read enable echo not a copy");
  chk_ren_off:
    assert property (!rs_q && !$past(rs_q) |-> !read_enable_echo)
    else $error("read enable echo with unclocked reads");
  // the controller must keep fall-through off for an unclocked read port; the device drops it too
  chk_async_std:
    assert property (!master_reset_n && !read_port_timing_strap |-> !fallthrough_mode_select_si)
    else $error("fall-through requested with unclocked reads");
  chk_mrs_clears:
    assert property (!master_reset_n |=> full_flag_n == !ft_q && half_full_flag_n && !almost_empty_flag)
    else $error("flags wrong after master reset");
  chk_empty_flags:
    assert property (!ft_q && !empty_flag_n |-> half_full_flag_n && !almost_empty_flag)
    else $error("empty storage with count flags set");
  chk_full_flags:
    assert property (!ft_q && !full_flag_n |-> !half_full_flag_n && !almost_full_flag && empty_flag_n)
    else $error("full storage with inconsistent flags");
  chk_ready_flags:
    assert property (ft_q && full_flag_n |-> !almost_full_flag && !half_full_flag_n)
    else $error("no space in fall-through mode but count flags disagree");
  chk_full_holds:
    assert property (master_reset_n && !ft_q && !full_flag_n && !read_en |=> !full_flag_n)
    else $error("full flag dropped without a read");
  chk_empty_holds:
    assert property (master_reset_n && !ft_q && !empty_flag_n && !write_en |=> !empty_flag_n)
    else $error("empty flag dropped without a write");
  cov_ready_full: cover property (ft_q && full_flag_n);
  cov_ren_echo: cover property (rs_q && read_enable_echo);
  cov_full_write: cover property (!ft_q && !full_flag_n && write_en);
  cov_unclocked: cover property (!rs_q && master_reset_n);
endmodule
`default_nettype wire

/* File: tb/dual_port_fifo_mode_and_flags_test.sv */
// self-checking bench: controller and device joined by the link, driven over AHB-Lite
// assumes a zero-wait slave; depth shrunk to 16 so fills stay short
`timescale 1ns/1ps
`default_nettype none
module dual_port_fifo_mode_and_flags_test;
  import dpf_pkg::*;
  localparam int D = 16;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] st;
  logic [31:0] rd;
  logic [31:0] c;
  logic [17:0] w;
  logic seen;
  logic [31:0] seed = 32'h0000_aa48;
  logic [17:0] q[$];
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  dpf_link_if link ();
  dpf_host dpf_host_i (.CLOCK(clock), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .LINK(link.host));
  dpf_device #(.DEPTH(D)) dpf_device_i (.CLOCK(clock), .SRST(srst), .LINK(link.dev));
  dpf_link_props dpf_link_props_i (.CLOCK(clock), .SRST(srst),
    .master_reset_n(link.master_reset_n), .read_port_timing_strap(link.read_port_timing_strap),
    .fallthrough_mode_select_si(link.fallthrough_mode_select_si), .read_clock(link.read_clock), .read_en(link.read_en),
    .write_en(link.write_en), .read_clock_echo(link.read_clock_echo),
    .read_enable_echo(link.read_enable_echo), .empty_flag_n(link.empty_flag_n),
    .full_flag_n(link.full_flag_n), .half_full_flag_n(link.half_full_flag_n),
    .almost_empty_flag(link.almost_empty_flag), .almost_full_flag(link.almost_full_flag));
  always #2 clock = ~clock;
  function automatic logic [17:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[17:0];
  endfunction
  // status bits {almost_full, almost_empty, half_full_n, full_n, empty_n} in standard mode
  function automatic logic [4:0] exp_st(input int n, input int ae, input int af);
    return {(D - n) > af, n >= ae, !(n > D / 2), n != D, n != 0};
  endfunction
  function automatic logic [31:0] cfg(input logic rs, input logic ws, input logic ord,
    input logic par, input logic [2:0] idx, input logic ft, input logic i9, input logic o9);
    return {21'h00_0000, o9, i9, ft, idx, par, ord, ws, rs, 1'b1};
  endfunction
  // timing, order, parity and select straps flipped on release: the device must keep what it caught
  function automatic logic [31:0] rel(input logic [31:0] v, input logic ldr);
    return {v[31:8], ldr, ~v[6:1], 1'b0};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rdv = hrdata;
    check(32'(hresp), 32'h0000_0000, "bus response");
  endtask
  task automatic stat();
    repeat (2) @(posedge clock);
    bus(1'b0, DPF_A_STATUS, 32'h0000_0000, st);
  endtask
  task automatic setup(input logic [31:0] v, input logic ldr);
    bus(1'b1, DPF_A_CTRL, v, rd);
    bus(1'b1, DPF_A_CTRL, rel(v, ldr), rd);
  endtask
  task automatic pop_word();
    bus(1'b1, DPF_A_RCMD, 32'h0000_0000, rd);
    repeat (2) @(posedge clock);
    bus(1'b0, DPF_A_RDATA, 32'h0000_0000, rd);
  endtask
  // one write past full and one read past empty, both refused
  task automatic fill_drain(input int ae, input int af);
    logic [17:0] v;
    for (int n = 1; n <= D + 1; n++) begin
      v = rnd();
      bus(1'b1, DPF_A_WDATA, {14'h0000, v}, rd);
      if (n <= D) q.push_back(v);
      stat();
      check(32'(st[4:0]), 32'(exp_st(n > D ? D : n, ae, af)), "fill status");
    end
    while (q.size() > 0) begin
      v = q.pop_front();
      pop_word();
      check(rd, {14'h0000, v}, "read data");
      stat();
      check(32'(st[4:0]), 32'(exp_st(q.size(), ae, af)), "drain status");
    end
    pop_word();
    stat();
    check(32'(st[4:0]), 32'(exp_st(0, ae, af)), "read when empty");
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      $display("[FAIL] t=%0t run too long", $time);
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    bus(1'b0, DPF_A_CTRL, 32'h0000_0000, rd);
    check(rd, 32'h0000_0087, "control reset value");
    bus(1'b1, 8'h18, 32'hffff_ffff, rd);
    bus(1'b0, 8'h18, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    $display("test registers done");
    for (int r = 0; r < 2; r++) begin
      setup(cfg(r[0], 1'b1, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0, 1'b0), 1'b1);
      seen = 1'b0;
      for (int i = 0; i < 4; i++) begin
        @(posedge clock);
        stat();
        seen |= st[5];
        if (r == 0) check(32'(st[6:5]), 32'h0000_0000, "echo while unclocked");
      end
      check(32'(seen), 32'(r), "clock echo");
    end
    $display("test echo done");
    // unclocked read port on half of the passes so the edge-strobe read path is used
    for (int i = 0; i < 8; i++) begin
      setup(cfg(~i[1], i[0], 1'b0, 1'b0, i[2:0], 1'b0, 1'b0, 1'b0), 1'b1);
      fill_drain(int'(DPF_DEF_OFS[i]), int'(DPF_DEF_OFS[i]));
    end
    $display("test default offsets done");
    for (int k = 0; k < 3; k++) begin
      setup(cfg(1'b1, 1'b1, k[0], 1'b0, 3'd0, 1'b0, k[1], 1'b1), 1'b1);
      w = k[1] ? (rnd() & 18'h0_01ff) : rnd();
      bus(1'b1, DPF_A_WDATA, {14'h0000, w}, rd);
      for (int b = 0; b < 2 - k[1]; b++) begin
        pop_word();
        check(32'(rd[8:0]), 32'(((b != int'(k[0])) || k[1]) ? w[8:0] : w[17:9]), "byte");
      end
    end
    $display("test byte order done");
    setup(cfg(1'b1, 1'b1, 1'b0, 1'b0, 3'd0, 1'b1, 1'b0, 1'b0), 1'b1);
    stat();
    check(32'(st[4:0]), 32'h0000_0015, "fall-through idle");
    bus(1'b1, DPF_A_WDATA, {14'h0000, rnd()}, rd);
    stat();
    check(32'(st[4:0]), 32'h0000_0014, "word presented");
    for (int i = 0; i < D; i++) bus(1'b1, DPF_A_WDATA, {14'h0000, rnd()}, rd);
    stat();
    check(32'(st[4:0]), 32'h0000_000a, "no space left");
    setup(cfg(1'b0, 1'b1, 1'b0, 1'b0, 3'd0, 1'b1, 1'b0, 1'b0), 1'b1);
    stat();
    check(32'(st[4:0]), 32'(exp_st(0, 7, 7)), "unclocked forces standard");
    $display("test fall-through done");
    for (int p = 0; p < 2; p++) begin
      c = cfg(1'b1, 1'b1, 1'b0, p[0], 3'd0, 1'b0, 1'b0, 1'b0);
      setup(c, 1'b0);
      bus(1'b1, DPF_A_WDATA, p ? 32'h0000_0103 : 32'h0003_0103, rd);
      bus(1'b1, DPF_A_WDATA, 32'h0000_0005, rd);
      bus(1'b1, DPF_A_CTRL, rel(c, 1'b1), rd);
      fill_drain(p ? 3 : 259, 5);
    end
    c = cfg(1'b1, 1'b1, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0, 1'b0);
    setup(c, 1'b0);
    for (int i = 31; i >= 0; i--) bus(1'b1, DPF_A_SERIAL, {31'h0, 1'(32'h0004_0006 >> i)}, rd);
    bus(1'b1, DPF_A_CTRL, rel(c, 1'b1), rd);
    fill_drain(4, 6);
    $display("test offset loading done");
    final_report();
  end
endmodule
`default_nettype wire
